// ### logic/ppc_port_phy_control.sv
// Per-port transmit rate-limit enables and PHY link control registers
//
// Overview of operation
// - Per-port low-priority egress rate-limit enable, reset zero.
// - Per-port high-priority egress rate-limit enable, reset zero.
// - Differential set: high and low frames limited by their own counters.
// - Differential clear: all frames limited by the low-priority counter.
// - Bit 7 enables autoneg; when clear bits 6 and 5 fix speed, duplex.
// - Autoneg off: speed bit one forces 100 Mb/s, zero forces 10.
// - Duplex bit selects full/half when autoneg off or autoneg failed.
// - Bit 4 offers pause ability to the link partner.
// - Bit 3 offers 100 Mb/s full duplex, reset one.
// - Bit 2 offers 100 Mb/s half duplex, reset one.
// - Link control of port one and two at their own addresses.
// - Third port link control location is reserved, reads zero.
// - Link control also reachable through the MIIM register path.
`default_nettype none
`include "ppc_regs.svh"

module ppc_port_phy_control #(
    parameter int NUM_PHYS = `PPC_NUM_PHYS
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Management host register port
    input wire ppc_pkg::ppc_req_t host_req_i,
    output logic [7:0] host_rdata_o,
    // MIIM register path (second access route)
    input wire ppc_pkg::ppc_req_t miim_req_i,
    output logic [7:0] miim_rdata_o,
    output logic miim_busy_o,
    // Strap pins, sampled while reset is held
    input wire ppc_pkg::ppc_strap_t first_port_strap_i,
    input wire ppc_pkg::ppc_strap_t second_port_strap_i,
    input wire logic pause_advertise_strap_i,
    // PHY side
    input wire logic [NUM_PHYS-1:0] an_failed_i,
    output ppc_pkg::ppc_link_t [NUM_PHYS-1:0] link_cfg_o,
    output logic [NUM_PHYS-1:0] link_100_o,
    output logic [NUM_PHYS-1:0] link_full_o,
    // Egress rate limiter steering, one entry per port
    output ppc_pkg::ppc_rate_t [`PPC_NUM_PORTS-1:0] rate_cfg_o
);
    import ppc_pkg::*;

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------

    // Link control register index of an address, or NUM_PHYS if none
    function automatic int link_index(input logic [7:0] a);
        if (a == `PPC_P1_LINK_CTRL_ADDR) begin
            return 0;
        end else if (a == `PPC_P2_LINK_CTRL_ADDR) begin
            return 1;
        end
        return NUM_PHYS;
    endfunction

    // Rate control register index of an address, or port count if none
    function automatic int rate_index(input logic [7:0] a);
        if (a == `PPC_P1_RATE_CTRL_ADDR) begin
            return 0;
        end else if (a == `PPC_P2_RATE_CTRL_ADDR) begin
            return 1;
        end else if (a == `PPC_P3_RATE_CTRL_ADDR) begin
            return 2;
        end
        return `PPC_NUM_PORTS;
    endfunction

    // ------------------------------------------------------------
    // Strap synchronisers
    // ------------------------------------------------------------

    logic [6:0] strap_meta_reg;
    logic [6:0] strap_sync_reg;
    logic [6:0] strap_raw;
    logic rst_seen_reg;

    assign strap_raw = {first_port_strap_i, second_port_strap_i, pause_advertise_strap_i};

    // Straps are pins, so two flops before anything looks at them
    always_ff @(posedge clk_i) begin
        strap_meta_reg <= strap_raw;
        strap_sync_reg <= strap_meta_reg;
    end

    // Marks that reset has been applied at least once
    always_ff @(posedge clk_i) begin
        rst_seen_reg <= sys_rst_i | rst_seen_reg;
    end

    // ------------------------------------------------------------
    // Access arbitration
    // ------------------------------------------------------------

    // Host wins a same-cycle clash; MIIM sees busy and must retry
    ppc_req_t req;
    ppc_src_t src;
    always_comb begin
        req = host_req_i;
        src = PPC_SRC_IDLE;
        if (host_req_i.wr || host_req_i.rd) begin
            src = PPC_SRC_HOST;
        end else if (miim_req_i.wr || miim_req_i.rd) begin
            req = miim_req_i;
            src = PPC_SRC_MIIM;
        end
    end

    assign miim_busy_o = (miim_req_i.wr || miim_req_i.rd) && (src == PPC_SRC_HOST);

    // ------------------------------------------------------------
    // Link control registers
    // ------------------------------------------------------------

    logic [7:0] link_ctrl_reg [NUM_PHYS];
    ppc_strap_t port_strap [NUM_PHYS];

    // Strap values per PHY, taken from the synchronised copy
    always_comb begin
        for (int i = 0; i < NUM_PHYS; i++) begin
            port_strap[i] = (i == 0) ? strap_sync_reg[6:4] : strap_sync_reg[3:1];
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_PHYS; g++) begin : gen_link
            // advertise 100 bits reset to one
            always_ff @(posedge clk_i) begin
                if (sys_rst_i) begin
                    link_ctrl_reg[g][`PPC_LC_AN_EN_BIT] <= port_strap[g].autoneg;
                    link_ctrl_reg[g][`PPC_LC_SPEED_BIT] <= port_strap[g].speed;
                    link_ctrl_reg[g][`PPC_LC_DUPLEX_BIT] <= port_strap[g].duplex;
                    link_ctrl_reg[g][`PPC_LC_ADV_PAUSE_BIT] <= strap_sync_reg[0];
                    link_ctrl_reg[g][3:0] <= `PPC_LC_LOW_RESET;
                end else if (req.wr && link_index(req.addr) == g) begin
                    link_ctrl_reg[g] <= req.wdata;
                end
            end

            always_comb begin
                link_cfg_o[g].an_en = link_ctrl_reg[g][`PPC_LC_AN_EN_BIT];
                link_cfg_o[g].force_100 = link_ctrl_reg[g][`PPC_LC_SPEED_BIT];
                link_cfg_o[g].force_full = link_ctrl_reg[g][`PPC_LC_DUPLEX_BIT];
                link_cfg_o[g].adv_pause = link_ctrl_reg[g][`PPC_LC_ADV_PAUSE_BIT];
                link_cfg_o[g].adv_100fd = link_ctrl_reg[g][`PPC_LC_ADV_100FD_BIT];
                link_cfg_o[g].adv_100hd = link_ctrl_reg[g][`PPC_LC_ADV_100HD_BIT];
                // With autoneg on, speed is the negotiated one; report the best offered
                link_100_o[g] = link_ctrl_reg[g][`PPC_LC_AN_EN_BIT] ?
                    (link_ctrl_reg[g][`PPC_LC_ADV_100FD_BIT] |
                     link_ctrl_reg[g][`PPC_LC_ADV_100HD_BIT]) :
                    link_ctrl_reg[g][`PPC_LC_SPEED_BIT];
                link_full_o[g] = (link_ctrl_reg[g][`PPC_LC_AN_EN_BIT] && !an_failed_i[g]) ?
                    link_ctrl_reg[g][`PPC_LC_ADV_100FD_BIT] :
                    link_ctrl_reg[g][`PPC_LC_DUPLEX_BIT];
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Transmit rate control registers
    // ------------------------------------------------------------

    logic [7:0] rate_ctrl_reg [`PPC_NUM_PORTS];

    generate
        for (g = 0; g < `PPC_NUM_PORTS; g++) begin : gen_rate
            always_ff @(posedge clk_i) begin
                if (sys_rst_i) begin
                    rate_ctrl_reg[g] <= `PPC_RC_RESET;
                end else if (req.wr && rate_index(req.addr) == g) begin
                    rate_ctrl_reg[g] <= req.wdata;
                end
            end

            // Limiter steering
            always_comb begin
                // non-differential uses low counter for all
                rate_cfg_o[g].lo_limit_all = !rate_ctrl_reg[g][`PPC_RC_DIFF_BIT] &&
                    rate_ctrl_reg[g][`PPC_RC_LO_EN_BIT];
                rate_cfg_o[g].lo_limit_lo = rate_ctrl_reg[g][`PPC_RC_DIFF_BIT] &&
                    rate_ctrl_reg[g][`PPC_RC_LO_EN_BIT];
                rate_cfg_o[g].hi_limit_hi = rate_ctrl_reg[g][`PPC_RC_DIFF_BIT] &&
                    rate_ctrl_reg[g][`PPC_RC_HI_EN_BIT];
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------

    logic [7:0] rd_value;
    always_comb begin
        rd_value = `PPC_RSVD_READ;
        if (link_index(req.addr) < NUM_PHYS) begin
            rd_value = link_ctrl_reg[link_index(req.addr)];
        end else if (rate_index(req.addr) < `PPC_NUM_PORTS) begin
            rd_value = rate_ctrl_reg[rate_index(req.addr)];
        end
        // third port location reads zero, writes dropped
        if (req.addr == `PPC_P3_LINK_CTRL_ADDR) begin
            rd_value = `PPC_RSVD_READ;
        end
    end

    // Read data registered one cycle after the request, per path
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            host_rdata_o <= `PPC_RSVD_READ;
            miim_rdata_o <= `PPC_RSVD_READ;
        end else begin
            if (src == PPC_SRC_HOST && req.rd) begin
                host_rdata_o <= rd_value;
            end
            if (src == PPC_SRC_MIIM && req.rd) begin
                miim_rdata_o <= rd_value;
            end
        end
    end

endmodule
`default_nettype wire

// ### logic/ppc_regs.svh
// Register offsets, field positions, reset values and port count for port/PHY control
`ifndef PPC_REGS_SVH
`define PPC_REGS_SVH

`define PPC_P1_LINK_CTRL_ADDR 8'h1c
`define PPC_P2_LINK_CTRL_ADDR 8'h2c
`define PPC_P3_LINK_CTRL_ADDR 8'h3c
`define PPC_P1_RATE_CTRL_ADDR 8'h1b
`define PPC_P2_RATE_CTRL_ADDR 8'h2b
`define PPC_P3_RATE_CTRL_ADDR 8'h3b

`define PPC_LC_AN_EN_BIT 7
`define PPC_LC_SPEED_BIT 6
`define PPC_LC_DUPLEX_BIT 5
`define PPC_LC_ADV_PAUSE_BIT 4
`define PPC_LC_ADV_100FD_BIT 3
`define PPC_LC_ADV_100HD_BIT 2

`define PPC_RC_DIFF_BIT 2
`define PPC_RC_LO_EN_BIT 1
`define PPC_RC_HI_EN_BIT 0

`define PPC_LC_LOW_RESET 4'hf
`define PPC_RC_RESET 8'h00
`define PPC_RSVD_READ 8'h00
`define PPC_NUM_PORTS 3
`define PPC_NUM_PHYS 2

`endif

// ### logic/ppc_pkg.sv
// Types shared by the port/PHY control block
`default_nettype none
package ppc_pkg;
    // Register access request from the management host or the MIIM path
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ppc_req_t;

    // Strap levels for one PHY port
    typedef struct packed {
        logic autoneg;
        logic speed;
        logic duplex;
    } ppc_strap_t;

    // Link settings presented to one PHY
    typedef struct packed {
        logic an_en;
        logic force_100;
        logic force_full;
        logic adv_pause;
        logic adv_100fd;
        logic adv_100hd;
    } ppc_link_t;

    // Egress rate limiter steering for one port
    typedef struct packed {
        logic lo_limit_all;
        logic lo_limit_lo;
        logic hi_limit_hi;
    } ppc_rate_t;

    // Which path a request arrived on
    typedef enum logic [1:0] {
        PPC_SRC_IDLE = 2'b00,
        PPC_SRC_HOST = 2'b01,
        PPC_SRC_MIIM = 2'b10
    } ppc_src_t;
endpackage
`default_nettype wire

// ### test/ppc_sva.sv
// Assertion checker for the port/PHY control registers
`default_nettype none
module ppc_sva
    import ppc_pkg::*;
#(
    parameter int NUM_PHYS = 2
) (
    // Clock, reset and requests
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire ppc_pkg::ppc_req_t host_req_i,
    input wire ppc_pkg::ppc_req_t miim_req_i,
    input wire logic [NUM_PHYS-1:0] an_failed_i,
    // Watched outputs
    input wire logic [7:0] host_rdata_o,
    input wire logic miim_busy_o,
    input wire ppc_pkg::ppc_link_t [NUM_PHYS-1:0] link_cfg_o,
    input wire logic [NUM_PHYS-1:0] link_100_o,
    input wire logic [NUM_PHYS-1:0] link_full_o,
    input wire ppc_pkg::ppc_rate_t [2:0] rate_cfg_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // Strobe shorthands and last write data, kept so rate steering can be judged
    wire logic host_on = host_req_i.wr | host_req_i.rd;
    wire logic miim_on = miim_req_i.wr | miim_req_i.rd;
    wire ppc_link_t c0 = link_cfg_o[0];
    logic [2:0] w_q;
    always_ff @(posedge clk_i) begin
        w_q <= host_req_i.wdata[2:0];
    end
    property p_busy; miim_busy_o == (miim_on && host_on); endproperty
    a_busy: assert property (p_busy) else $error("miim drop flag wrong");
    property p_p1_wr; host_req_i.wr && host_req_i.addr == 8'h1c
        |=> link_cfg_o[0] == $past(host_req_i.wdata[7:2]); endproperty
    a_p1_wr: assert property (p_p1_wr) else $error("port one write lost");
    property p_p2_wr; miim_req_i.wr && !host_on && miim_req_i.addr == 8'h2c
        |=> link_cfg_o[1] == $past(miim_req_i.wdata[7:2]); endproperty
    a_p2_wr: assert property (p_p2_wr) else $error("port two miim write lost");
    property p_rsvd; host_req_i.rd && host_req_i.addr == 8'h3c
        |=> host_rdata_o == 8'h00; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved read not zero");
    property p_rate; host_req_i.wr && host_req_i.addr == 8'h1b
        |=> rate_cfg_o[0] == {~w_q[2] & w_q[1], w_q[2] & w_q[1], w_q[2] & w_q[0]}; endproperty
    a_rate: assert property (p_rate) else $error("rate steering wrong");
    property p_spd; link_100_o[0] == (c0.an_en ? c0.adv_100fd | c0.adv_100hd : c0.force_100);
    endproperty
    a_spd: assert property (p_spd) else $error("speed in use wrong");
    property p_dpx; link_full_o[0] == (c0.an_en && !an_failed_i[0] ? c0.adv_100fd : c0.force_full);
    endproperty
    a_dpx: assert property (p_dpx) else $error("duplex in use wrong");
    property p_rst; $fell(sys_rst_i) |-> c0.adv_100fd && c0.adv_100hd && rate_cfg_o == 9'h000;
    endproperty
    a_rst: assert property (p_rst) else $error("reset values wrong");
    c_busy: cover property (miim_busy_o);
    c_an_fail: cover property (c0.an_en && an_failed_i[0]);
    c_rsvd: cover property (host_req_i.rd && host_req_i.addr == 8'h3c);
endmodule

bind ppc_port_phy_control ppc_sva #(.NUM_PHYS(NUM_PHYS)) u_sva (
    .clk_i, .sys_rst_i, .host_req_i, .miim_req_i, .an_failed_i, .host_rdata_o,
    .miim_busy_o, .link_cfg_o, .link_100_o, .link_full_o, .rate_cfg_o
);
`default_nettype wire

// ### test/ppc_host_model.sv
// Management host model driving both register access paths
`default_nettype none
module ppc_host_model
    import ppc_pkg::*;
(
    // Clock and answers
    input wire logic clk_i,
    input wire logic [7:0] host_rdata_i,
    input wire logic [7:0] miim_rdata_i,
    input wire logic miim_busy_i,
    // Requests
    output ppc_pkg::ppc_req_t host_req_o,
    output ppc_pkg::ppc_req_t miim_req_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle at time zero
    initial begin
        host_req_o = '0;
        miim_req_o = '0;
    end
    // One request per path after gap idle cycles; released fields flip so stale data never looks live
    task automatic xfer(input int gap, input ppc_req_t h, input ppc_req_t m,
                        output logic [7:0] hr, output logic [7:0] mr, output logic busy);
        repeat (gap) @(posedge clk_i);
        @(posedge clk_i);
        host_req_o <= h;
        miim_req_o <= m;
        #1 busy = miim_busy_i;
        @(posedge clk_i);
        host_req_o <= '{1'b0, 1'b0, ~h.addr, ~h.wdata};
        miim_req_o <= '{1'b0, 1'b0, ~m.addr, ~m.wdata};
        #1 hr = host_rdata_i;
        mr = miim_rdata_i;
    endtask
endmodule
`default_nettype wire

// ### test/tb_top.sv
// Self-checking bench for the port/PHY control registers
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import ppc_pkg::*;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    ppc_strap_t s1, s2;
    logic pause_s, miim_busy, busy;
    logic [1:0] an_fail = 2'b00;
    ppc_req_t host_req, miim_req;
    logic [7:0] host_rdata, miim_rdata, hr, mr;
    logic [7:0] seed = 8'h12;
    ppc_link_t [1:0] link_cfg;
    logic [1:0] link_100, link_full;
    ppc_rate_t [2:0] rate_cfg;
    logic [7:0] lc [2];
    logic [7:0] rc [3];
    int miscompares = 0, checked = 0, cyc = 0;
    ppc_port_phy_control u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .host_req_i(host_req),
        .host_rdata_o(host_rdata), .miim_req_i(miim_req), .miim_rdata_o(miim_rdata),
        .miim_busy_o(miim_busy), .first_port_strap_i(s1), .second_port_strap_i(s2),
        .pause_advertise_strap_i(pause_s), .an_failed_i(an_fail), .link_cfg_o(link_cfg),
        .link_100_o(link_100), .link_full_o(link_full), .rate_cfg_o(rate_cfg));
    ppc_host_model u_host (.clk_i(clk_i), .host_rdata_i(host_rdata), .miim_rdata_i(miim_rdata),
        .miim_busy_i(miim_busy), .host_req_o(host_req), .miim_req_o(miim_req));
    // 125 MHz clock
    initial begin
        forever #4 clk_i = ~clk_i;
    end
    // Cycle ceiling so a hung run still reports
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            miscompares = miscompares + 1;
            tally_and_finish();
        end
    end
    // -------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic ppc_rate_t exp_rate(input logic [7:0] r);
        return '{~r[2] & r[1], r[2] & r[1], r[2] & r[0]};
    endfunction
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic check_all();
        for (int i = 0; i < 2; i++) begin
            chk("link cfg", {2'h0, lc[i][7:2]}, {2'h0, link_cfg[i]});
            chk("speed", {7'h00, lc[i][7] ? |lc[i][3:2] : lc[i][6]}, {7'h00, link_100[i]});
            chk("duplex", {7'h00, lc[i][7] && !an_fail[i] ? lc[i][3] : lc[i][5]},
                {7'h00, link_full[i]});
        end
        for (int i = 0; i < 3; i++) begin
            chk("rate cfg", {5'h00, exp_rate(rc[i])}, {5'h00, rate_cfg[i]});
        end
    endtask
    // One access on either path, updating the expected register image
    task automatic acc(input logic miim, input logic wr, input logic [7:0] a, input logic [7:0] d);
        ppc_req_t r;
        r = '{wr, ~wr, a, d};
        u_host.xfer(0, miim ? '0 : r, miim ? r : '0, hr, mr, busy);
        if (wr && a[3:0] == 4'hc && a[7:4] inside {4'h1, 4'h2}) lc[a[5]] = d;
        if (wr && a[3:0] == 4'hb && a[7:4] inside {4'h1, 4'h2, 4'h3}) rc[a[5:4] - 1] = d;
        if (!wr) chk("read", a == 8'h1c ? lc[0] : a == 8'h2c ? lc[1] :
            (a[3:0] == 4'hb && a[7:4] inside {4'h1, 4'h2, 4'h3}) ? rc[a[5:4] - 1] : 8'h00,
            miim ? mr : hr);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Main sequence: straps held through reset, then corners and random traffic
    initial begin
        s1 = ppc_strap_t'(3'(lfsr(seed) >> 1));
        s2 = ppc_strap_t'(seed[5:3]);
        pause_s = seed[4];
        repeat (5) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        lc[0] = {s1, pause_s, 4'hf};
        lc[1] = {s2, pause_s, 4'hf};
        rc = '{3{8'h00}};
        @(posedge clk_i);
        #1 check_all();
        acc(1'b0, 1'b0, 8'h1c, 8'h00);
        acc(1'b1, 1'b0, 8'h2c, 8'h00);
        acc(1'b0, 1'b1, 8'h3c, 8'hff);
        acc(1'b0, 1'b0, 8'h3c, 8'h00);
        acc(1'b1, 1'b0, 8'h10, 8'h00);
        for (int v = 0; v < 24; v++) begin
            acc(1'b0, 1'b1, {2'h0, 2'(v % 3 + 1), 4'hb}, 8'(v / 3));
            check_all();
        end
        // Rate registers read back on both paths
        acc(1'b1, 1'b0, 8'h3b, 8'h00);
        acc(1'b0, 1'b0, 8'h1b, 8'h00);
        for (int n = 0; n < 40; n++) begin
            seed = lfsr(seed);
            @(posedge clk_i) an_fail <= seed[2:1];
            acc(seed[0], 1'b1, seed[7] ? 8'h2c : 8'h1c, lfsr(seed));
            check_all();
            acc(seed[3], 1'b0, seed[6] ? 8'h2c : 8'h1c, 8'h00);
        end
        u_host.xfer(2, '{1'b1, 1'b0, 8'h1c, 8'h00}, '{1'b1, 1'b0, 8'h1c, 8'hff}, hr, mr, busy);
        lc[0] = 8'h00;
        chk("miim busy", 8'h01, {7'h00, busy});
        check_all();
        tally_and_finish();
    end
endmodule
`default_nettype wire
